// ---- exec_consts.vh ----
// Constants for the bit, stack, I/O and atomic instruction execution unit.
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

// Operation codes presented on op_i.
`define OP_NOP        5'h00
`define OP_PMEM_STORE 5'h01
`define OP_IO_IN      5'h02
`define OP_IO_OUT     5'h03
`define OP_PUSH       5'h04
`define OP_POP        5'h05
`define OP_XCH        5'h06
`define OP_LD_SET     5'h07
`define OP_LD_CLEAR   5'h08
`define OP_LD_TOGGLE  5'h09
`define OP_ROT_LEFT   5'h0a
`define OP_ROT_RIGHT  5'h0b
`define OP_IO_BSET    5'h0c
`define OP_IO_BCLR    5'h0d
`define OP_BIT_TO_T   5'h0e
`define OP_T_TO_BIT   5'h0f
`define OP_FLAG_SET   5'h10
`define OP_FLAG_CLEAR 5'h11
`define OP_WDOG_KICK  5'h12
`define OP_SLEEP      5'h13
`define OP_BREAK      5'h14

// Status register bit positions.
`define SR_C 0
`define SR_Z 1
`define SR_N 2
`define SR_V 3
`define SR_S 4
`define SR_H 5
`define SR_T 6
`define SR_I 7

// Reset values, step sizes and the SRAM extra-clock switch.
`define STATUS_REGISTER_RESET   8'h00
`define ZPTR_STEP    24'h000002
`define SRAM_EXTRA   1

`endif

// ---- rotate_unit.v ----
// Rotate-through-carry unit with status flag results.
`timescale 1ns/1ps
`include "exec_consts.vh"
module rotate_unit (
  // Operands
  input  wire [7:0] val_i,
  input  wire       carry_i,
  input  wire       half_i,
  input  wire       left_i,
  // Results
  output reg  [7:0] res_o,
  output reg  [7:0] flag_mask_o,
  output reg  [7:0] flag_val_o
);
  reg c;
  reg n;
  reg v;

  // Rotation and flag computation for either direction.
  always @* begin
    if (left_i) begin
      res_o = {val_i[6:0], carry_i};
      c     = val_i[7];
    end else begin
      res_o = {carry_i, val_i[7:1]};
      c     = val_i[0];
    end
    n = res_o[7];
    v = n ^ c;
    flag_val_o        = 8'h00;
    flag_val_o[`SR_C] = c;
    flag_val_o[`SR_Z] = (res_o == 8'h00);
    flag_val_o[`SR_N] = n;
    flag_val_o[`SR_V] = v;
    flag_val_o[`SR_S] = n ^ v;
    flag_val_o[`SR_H] = left_i ? val_i[3] : half_i;
    flag_mask_o       = 8'h00;
    flag_mask_o[`SR_C] = 1'b1;
    flag_mask_o[`SR_Z] = 1'b1;
    flag_mask_o[`SR_N] = 1'b1;
    flag_mask_o[`SR_V] = 1'b1;
    flag_mask_o[`SR_S] = 1'b1;
    flag_mask_o[`SR_H] = left_i;
  end
endmodule

// ---- bit_ops.v ----
// Single-bit helpers: bit select, bit set, bit clear and bit insert.
`timescale 1ns/1ps
module bit_ops (
  // Operands
  input  wire [7:0] val_i,
  input  wire [2:0] sel_i,
  input  wire       bit_i,
  // Results
  output wire       picked_o,
  output wire [7:0] inserted_o
);
  genvar g;

  // Each lane takes the new bit when selected, else keeps its value.
  generate
    for (g = 0; g < 8; g = g + 1) begin : lane
      assign inserted_o[g] = (sel_i == g) ? bit_i : val_i[g];
    end
  endgenerate

  assign picked_o = val_i[sel_i];
endmodule

// ---- exec_unit.v ----
// Execution unit for I/O, stack, atomic memory, bit and flag instructions.
`timescale 1ns/1ps
`include "exec_consts.vh"

// Notes on behaviour
// - Program store writes r1:r0 at extended Z, then Z grows by two.
// - Port output copies one byte in one clock, port input in two clocks, no flags.
// - Stack push stores a register in one clock, flags untouched.
// - Stack pop loads a register in two clocks, flags untouched.
// - Exchange swaps register and byte at Z in two clocks.
// - Load-and-set returns old byte, writes register OR byte.
// - Load-and-clear returns old byte, writes byte AND inverted register.
// - Load-and-toggle returns old byte, writes register XOR byte.
// - Rotate left through carry, one clock, updates Z C N V S H.
// - Rotate right through carry, one clock, updates Z C N V S only.
// - I/O bit set forces one bit high in two clocks.
// - I/O bit clear forces one bit low in two clocks.
// - Bit store copies a register bit into T in one clock.
// - Bit load copies T into a register bit in one clock.
// - Flag set or clear changes only that flag in one clock.
// - Half-carry clear zeroes H only, in one clock.
// - Watchdog kick, sleep, break and no-op take one clock, no flags.
// - Cycle counts hold for internal memory only.
// - Footnoted accesses to internal SRAM add one extra clock.
module exec_unit #(
  parameter SRAM_EXTRA = `SRAM_EXTRA
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  // Instruction request
  input  wire        start_i,
  input  wire [4:0]  op_i,
  input  wire [7:0]  rd_val_i,
  input  wire [7:0]  r0_val_i,
  input  wire [7:0]  r1_val_i,
  input  wire [2:0]  bit_sel_i,
  input  wire [5:0]  io_addr_i,
  input  wire        sram_i,
  // Pointers
  input  wire [15:0] z_ptr_i,
  input  wire [7:0]  z_ext_i,
  input  wire [15:0] sp_i,
  // Memory and I/O read data
  input  wire [7:0]  dmem_rdata_i,
  input  wire [7:0]  io_rdata_i,
  // Status and results
  output reg         busy_o,
  output reg         done_o,
  output reg  [7:0]  status_register_o,
  output reg         rd_we_o,
  output reg  [7:0]  rd_wdata_o,
  output reg         z_we_o,
  output reg  [23:0] z_wdata_o,
  output reg         sp_we_o,
  output reg  [15:0] sp_wdata_o,
  // Data memory
  output reg         dmem_re_o,
  output reg         dmem_we_o,
  output reg  [15:0] dmem_addr_o,
  output reg  [7:0]  dmem_wdata_o,
  output reg         dmem_lock_o,
  // Program memory
  output reg         pmem_we_o,
  output reg  [23:0] pmem_addr_o,
  output reg  [15:0] pmem_wdata_o,
  // I/O space
  output reg         io_re_o,
  output reg         io_we_o,
  output reg  [5:0]  io_addr_o,
  output reg  [7:0]  io_wdata_o,
  // Control events
  output reg         wdog_kick_o,
  output reg         sleep_o,
  output reg         break_o
);
  // One-hot states.
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_READ  = 4'b0010;
  localparam [3:0] ST_WRITE = 4'b0100;
  localparam [3:0] ST_EXTRA = 4'b1000;

  reg [3:0]  state;
  reg [4:0]  op_hold;
  reg [7:0]  rd_hold;
  reg [2:0]  bit_hold;
  reg [5:0]  io_hold;
  reg        extra;
  reg [7:0]  next_wb;

  wire [7:0] rot_res;
  wire [7:0] rot_mask;
  wire [7:0] rot_val;
  wire       rd_bit;
  wire [7:0] rd_ins;
  wire [7:0] io_ins;
  wire [7:0] t_ins;
  wire [2:0] sel_mux;

  // Atomic opcode decode used by the idle-state dispatch.
  function is_atomic;
    input [4:0] op;
    begin
      is_atomic = (op == `OP_XCH) || (op == `OP_LD_SET) ||
                  (op == `OP_LD_CLEAR) || (op == `OP_LD_TOGGLE);
    end
  endfunction

  // Write-back value of an atomic operation from old register and byte.
  always @* begin
    case (op_hold)
      `OP_LD_SET:    next_wb = rd_hold | dmem_rdata_i;
      `OP_LD_CLEAR:  next_wb = (8'hff - rd_hold) & dmem_rdata_i;
      `OP_LD_TOGGLE: next_wb = rd_hold ^ dmem_rdata_i;
      default:       next_wb = rd_hold;
    endcase
  end

  rotate_unit u_rot (
    .val_i       (rd_val_i),
    .carry_i     (status_register_o[`SR_C]),
    .half_i      (status_register_o[`SR_H]),
    .left_i      (op_i == `OP_ROT_LEFT),
    .res_o       (rot_res),
    .flag_mask_o (rot_mask),
    .flag_val_o  (rot_val)
  );

  // Register bit insertion of T, and bit pick for the T store.
  bit_ops u_rdbits (
    .val_i      (rd_val_i),
    .sel_i      (bit_sel_i),
    .bit_i      (status_register_o[`SR_T]),
    .picked_o   (rd_bit),
    .inserted_o (t_ins)
  );

  assign rd_ins = t_ins;

  // I/O bit insertion for set and clear, held operands in the write state.
  bit_ops u_iobits (
    .val_i      (io_rdata_i),
    .sel_i      (sel_mux),
    .bit_i      (op_hold == `OP_IO_BSET),
    .picked_o   (),
    .inserted_o (io_ins)
  );

  assign sel_mux = bit_hold;

  // Main sequencer: one process for all registered outputs.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state             <= ST_IDLE;
      op_hold           <= `OP_NOP;
      rd_hold           <= 8'h00;
      bit_hold          <= 3'h0;
      io_hold           <= 6'h00;
      extra             <= 1'b0;
      busy_o            <= 1'b0;
      done_o            <= 1'b0;
      status_register_o <= `STATUS_REGISTER_RESET;
      rd_we_o           <= 1'b0;
      rd_wdata_o        <= 8'h00;
      z_we_o            <= 1'b0;
      z_wdata_o         <= 24'h000000;
      sp_we_o           <= 1'b0;
      sp_wdata_o        <= 16'h0000;
      dmem_re_o         <= 1'b0;
      dmem_we_o         <= 1'b0;
      dmem_addr_o       <= 16'h0000;
      dmem_wdata_o      <= 8'h00;
      dmem_lock_o       <= 1'b0;
      pmem_we_o         <= 1'b0;
      pmem_addr_o       <= 24'h000000;
      pmem_wdata_o      <= 16'h0000;
      io_re_o           <= 1'b0;
      io_we_o           <= 1'b0;
      io_addr_o         <= 6'h00;
      io_wdata_o        <= 8'h00;
      wdog_kick_o       <= 1'b0;
      sleep_o           <= 1'b0;
      break_o           <= 1'b0;
    end else begin
      // Strobes last one cycle by default; the memory lock drops too.
      done_o      <= 1'b0;
      dmem_lock_o <= 1'b0;
      rd_we_o     <= 1'b0;
      z_we_o      <= 1'b0;
      sp_we_o     <= 1'b0;
      dmem_re_o   <= 1'b0;
      dmem_we_o   <= 1'b0;
      pmem_we_o   <= 1'b0;
      io_re_o     <= 1'b0;
      io_we_o     <= 1'b0;
      wdog_kick_o <= 1'b0;
      sleep_o     <= 1'b0;
      break_o     <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_i) begin
            op_hold  <= op_i;
            rd_hold  <= rd_val_i;
            bit_hold <= bit_sel_i;
            io_hold  <= io_addr_i;
            extra    <= sram_i && (SRAM_EXTRA != 0);
            case (op_i)
              `OP_PMEM_STORE: begin
                pmem_we_o    <= 1'b1;
                pmem_addr_o  <= {z_ext_i, z_ptr_i};
                pmem_wdata_o <= {r1_val_i, r0_val_i};
                z_we_o       <= 1'b1;
                z_wdata_o    <= {z_ext_i, z_ptr_i} + `ZPTR_STEP;
                done_o       <= 1'b1;
              end
              `OP_IO_IN: begin
                io_re_o   <= 1'b1;
                io_addr_o <= io_addr_i;
                busy_o    <= 1'b1;
                state     <= ST_WRITE;
              end
              `OP_IO_OUT: begin
                io_we_o    <= 1'b1;
                io_addr_o  <= io_addr_i;
                io_wdata_o <= rd_val_i;
                done_o     <= 1'b1;
              end
              `OP_PUSH: begin
                dmem_we_o    <= 1'b1;
                dmem_addr_o  <= sp_i;
                dmem_wdata_o <= rd_val_i;
                sp_we_o      <= 1'b1;
                sp_wdata_o   <= sp_i - 16'h0001;
                done_o       <= 1'b1;
              end
              `OP_POP: begin
                dmem_re_o   <= 1'b1;
                dmem_addr_o <= sp_i + 16'h0001;
                sp_we_o     <= 1'b1;
                sp_wdata_o  <= sp_i + 16'h0001;
                busy_o      <= 1'b1;
                state       <= ST_WRITE;
              end
              `OP_IO_BSET, `OP_IO_BCLR: begin
                io_re_o   <= 1'b1;
                io_addr_o <= io_addr_i;
                busy_o    <= 1'b1;
                state     <= ST_WRITE;
              end
              `OP_ROT_LEFT, `OP_ROT_RIGHT: begin
                rd_we_o           <= 1'b1;
                rd_wdata_o        <= rot_res;
                status_register_o <= (status_register_o & ~rot_mask) |
                                     (rot_val & rot_mask);
                done_o            <= 1'b1;
              end
              `OP_BIT_TO_T: begin
                status_register_o[`SR_T] <= rd_bit;
                done_o                   <= 1'b1;
              end
              `OP_T_TO_BIT: begin
                rd_we_o    <= 1'b1;
                rd_wdata_o <= rd_ins;
                done_o     <= 1'b1;
              end
              `OP_FLAG_SET: begin
                status_register_o[bit_sel_i] <= 1'b1;
                done_o                       <= 1'b1;
              end
              `OP_FLAG_CLEAR: begin
                status_register_o[bit_sel_i] <= 1'b0;
                done_o                       <= 1'b1;
              end
              `OP_WDOG_KICK: begin
                wdog_kick_o <= 1'b1;
                done_o      <= 1'b1;
              end
              `OP_SLEEP: begin
                sleep_o <= 1'b1;
                done_o  <= 1'b1;
              end
              `OP_BREAK: begin
                break_o <= 1'b1;
                done_o  <= 1'b1;
              end
              default: begin
                if (is_atomic(op_i)) begin
                  dmem_re_o   <= 1'b1;
                  dmem_addr_o <= z_ptr_i;
                  dmem_lock_o <= 1'b1;
                  busy_o      <= 1'b1;
                  state       <= ST_READ;
                end else begin
                  done_o <= 1'b1;
                end
              end
            endcase
          end
        end
        ST_READ: begin
          // Old byte is on the read bus: return it, write back and finish.
          rd_we_o      <= 1'b1;
          rd_wdata_o   <= dmem_rdata_i;
          dmem_we_o    <= 1'b1;
          dmem_wdata_o <= next_wb;
          dmem_lock_o  <= 1'b1;
          busy_o       <= 1'b0;
          done_o       <= 1'b1;
          state        <= ST_IDLE;
        end
        ST_WRITE: begin
          dmem_lock_o <= 1'b0;
          if (op_hold == `OP_IO_IN) begin
            rd_we_o    <= 1'b1;
            rd_wdata_o <= io_rdata_i;
          end else if (op_hold == `OP_POP) begin
            rd_we_o    <= 1'b1;
            rd_wdata_o <= dmem_rdata_i;
          end else if ((op_hold == `OP_IO_BSET) ||
                       (op_hold == `OP_IO_BCLR)) begin
            io_we_o    <= 1'b1;
            io_addr_o  <= io_hold;
            io_wdata_o <= io_ins;
          end
          if (extra && (op_hold == `OP_POP)) begin
            state <= ST_EXTRA;
          end else begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state  <= ST_IDLE;
          end
        end
        ST_EXTRA: begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state  <= ST_IDLE;
        end
        default: begin
          busy_o <= 1'b0;
          state  <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- exec_chk.sv ----
// Concurrent checks on the ports of the execution unit.
`timescale 1ns/1ps
`include "exec_consts.vh"
module exec_chk (
  // Clock, reset and request
  input wire        clk_sys_i, sys_rst_i, start_i, sram_i,
  input wire [4:0]  op_i,
  input wire [7:0]  rd_val_i, r0_val_i, r1_val_i, z_ext_i,
  input wire [2:0]  bit_sel_i,
  input wire [15:0] z_ptr_i, sp_i,
  input wire [7:0]  dmem_rdata_i, io_rdata_i,
  // Design outputs
  input wire        busy_o, done_o, rd_we_o, dmem_re_o, dmem_we_o,
  input wire        dmem_lock_o, pmem_we_o, io_re_o, io_we_o, wdog_kick_o,
  input wire [7:0]  status_register_o, rd_wdata_o, dmem_wdata_o, io_wdata_o,
  input wire [23:0] z_wdata_o, pmem_addr_o,
  input wire [15:0] sp_wdata_o, dmem_addr_o, pmem_wdata_o
);
  wire       take = start_i && !busy_o;
  reg  [4:0] op_q;
  reg  [7:0] rd_q;
  reg  [7:0] sr_q;
  reg  [2:0] sel_q;
  // Operands captured at the edge that takes a request.
  always @(posedge clk_sys_i) begin
    if (take) begin
      op_q  <= op_i;
      rd_q  <= rd_val_i;
      sr_q  <= status_register_o;
      sel_q <= bit_sel_i;
    end
  end
  // Write-back byte of each atomic operation.
  function [7:0] wb(input [4:0] op, input [7:0] r, input [7:0] m);
    case (op)
      `OP_LD_SET:    wb = r | m;
      `OP_LD_CLEAR:  wb = m & ~r;
      `OP_LD_TOGGLE: wb = r ^ m;
      default:       wb = r;
    endcase
  endfunction
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_pmem;
    take && op_i == `OP_PMEM_STORE |=> pmem_we_o
      && pmem_wdata_o == {$past(r1_val_i), $past(r0_val_i)}
      && pmem_addr_o == {$past(z_ext_i), $past(z_ptr_i)}
      && z_wdata_o == {$past(z_ext_i), $past(z_ptr_i)} + 24'h000002;
  endproperty
  a_pmem: assert property (p_pmem) else $error("program store wrong");
  property p_out;
    take && op_i == `OP_IO_OUT |=> io_we_o && done_o && io_wdata_o == rd_q;
  endproperty
  a_out: assert property (p_out) else $error("port output wrong");
  property p_in;
    take && op_i == `OP_IO_IN |=> io_re_o ##1 rd_we_o && done_o
      && rd_wdata_o == $past(io_rdata_i);
  endproperty
  a_in: assert property (p_in) else $error("port input wrong");
  property p_push;
    take && op_i == `OP_PUSH |=> dmem_we_o && done_o && dmem_wdata_o == rd_q
      && dmem_addr_o == $past(sp_i) && sp_wdata_o == $past(sp_i) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    take && op_i == `OP_POP && !sram_i |=> dmem_re_o
      && dmem_addr_o == $past(sp_i) + 16'h0001 ##1 done_o && rd_we_o;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_pop_sram;
    take && op_i == `OP_POP && sram_i |=> !done_o ##1 !done_o && rd_we_o
      ##1 done_o;
  endproperty
  a_pop_sram: assert property (p_pop_sram) else $error("sram pop time");
  property p_atom_wb;
    dmem_we_o && dmem_lock_o |-> rd_we_o && rd_wdata_o == $past(dmem_rdata_i)
      && dmem_wdata_o == wb(op_q, rd_q, $past(dmem_rdata_i));
  endproperty
  a_atom_wb: assert property (p_atom_wb) else $error("atomic data");
  property p_lock;
    take && op_i >= `OP_XCH && op_i <= `OP_LD_TOGGLE |=> dmem_re_o
      && dmem_lock_o && busy_o ##1 dmem_lock_o && dmem_we_o && done_o
      ##1 (!dmem_lock_o || dmem_re_o);
  endproperty
  a_lock: assert property (p_lock) else $error("atomic lock");
  property p_rotl;
    take && op_i == `OP_ROT_LEFT |=> rd_we_o && done_o
      && rd_wdata_o == {rd_q[6:0], sr_q[0]}
      && status_register_o[0] == rd_q[7] && status_register_o[5] == rd_q[3];
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left");
  property p_rotr;
    take && op_i == `OP_ROT_RIGHT |=> rd_we_o && done_o
      && rd_wdata_o == {sr_q[0], rd_q[7:1]} && status_register_o[0] == rd_q[0]
      && status_register_o[6:5] == sr_q[6:5];
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right");
  property p_flag;
    take && (op_i == `OP_FLAG_SET || op_i == `OP_FLAG_CLEAR) |=> done_o
      && status_register_o == (op_q == `OP_FLAG_SET ? sr_q | (8'h01 << sel_q)
                                                   : sr_q & ~(8'h01 << sel_q));
  endproperty
  a_flag: assert property (p_flag) else $error("flag write");
  property p_bst;
    take && op_i == `OP_BIT_TO_T |=> done_o
      && status_register_o == ((sr_q & 8'hbf) | ({7'h00, rd_q[sel_q]} << 6));
  endproperty
  a_bst: assert property (p_bst) else $error("bit store");
  property p_bld;
    take && op_i == `OP_T_TO_BIT |=> rd_we_o && status_register_o == sr_q
      && rd_wdata_o == ((rd_q & ~(8'h01 << sel_q)) | ({7'h00, sr_q[6]} << sel_q));
  endproperty
  a_bld: assert property (p_bld) else $error("bit load");
  property p_iobit;
    take && (op_i == `OP_IO_BSET || op_i == `OP_IO_BCLR) |=> io_re_o
      ##1 io_we_o && done_o && io_wdata_o == (op_q == `OP_IO_BSET
      ? $past(io_rdata_i) | (8'h01 << sel_q) : $past(io_rdata_i) & ~(8'h01 << sel_q));
  endproperty
  a_iobit: assert property (p_iobit) else $error("io bit write");
  property p_ctrl;
    take && (op_i == `OP_NOP || (op_i >= `OP_WDOG_KICK && op_i <= `OP_BREAK))
      |=> done_o && status_register_o == sr_q
      && wdog_kick_o == (op_q == `OP_WDOG_KICK);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control op");
  c_atom: cover property (take && op_i == `OP_LD_CLEAR);
  c_pop_sram: cover property (take && op_i == `OP_POP && sram_i);
  c_b2b: cover property (done_o && take);
endmodule
bind exec_unit exec_chk chk (.*);

// ---- mem_model.sv ----
// Byte memory answering reads in the strobe cycle, for data and I/O space.
`timescale 1ns/1ps
module mem_model #(
  parameter [7:0] FILL = 8'h00
) (
  // Clock
  input  wire        clk_sys_i,
  // Access
  input  wire        re_i,
  input  wire        we_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  output wire [7:0]  rdata_o
);
  reg [7:0] mem [0:255];
  reg       flip;
  integer   i;
  // Known contents so that expectations can be worked out.
  initial begin
    flip = 1'b0;
    for (i = 0; i < 256; i = i + 1) mem[i] = FILL ^ i[7:0];
  end
  // Internal memory answers at once; off strobe the lines keep changing.
  assign rdata_o = re_i ? mem[addr_i[7:0]] : {8{flip}};
  // Writes land at the edge that samples the strobe.
  always @(posedge clk_sys_i) begin
    flip <= ~flip;
    if (we_i) mem[addr_i[7:0]] <= wdata_i;
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
`include "exec_consts.vh"
module tb;
  // Stimulus
  reg         clk_sys_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0;
  reg         sram_i = 1'b0;
  reg  [4:0]  op_i = 5'h00;
  reg  [7:0]  rd_val_i = 8'h00, r0_val_i = 8'h00, r1_val_i = 8'h00;
  reg  [7:0]  z_ext_i = 8'h00;
  reg  [2:0]  bit_sel_i = 3'h0;
  reg  [5:0]  io_addr_i = 6'h00;
  reg  [15:0] z_ptr_i = 16'h0000, sp_i = 16'h0000;
  // Outputs and memory answers
  wire [7:0]  dmem_rdata_i, io_rdata_i, status_register_o, rd_wdata_o;
  wire [7:0]  dmem_wdata_o, io_wdata_o;
  wire        busy_o, done_o, rd_we_o, z_we_o, sp_we_o, dmem_re_o;
  wire        dmem_we_o, dmem_lock_o, pmem_we_o, io_re_o, io_we_o;
  wire        wdog_kick_o, sleep_o, break_o;
  wire [23:0] z_wdata_o, pmem_addr_o;
  wire [15:0] sp_wdata_o, dmem_addr_o, pmem_wdata_o;
  wire [5:0]  io_addr_o;
  integer     fails = 0, compares = 0, lat, k;
  exec_unit dut (.*);
  mem_model #(.FILL(8'ha0)) dmem (.clk_sys_i(clk_sys_i), .re_i(dmem_re_o),
    .we_i(dmem_we_o), .addr_i(dmem_addr_o), .wdata_i(dmem_wdata_o),
    .rdata_o(dmem_rdata_i));
  mem_model #(.FILL(8'h50)) iomem (.clk_sys_i(clk_sys_i), .re_i(io_re_o),
    .we_i(io_we_o), .addr_i({10'h000, io_addr_o}), .wdata_i(io_wdata_o),
    .rdata_o(io_rdata_i));
  // Clock of 50 ns.
  always #25 clk_sys_i = ~clk_sys_i;
  task check(input string what, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fails = fails + 1;
    end
  endtask
  task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Issues one request at a falling edge and counts clocks to done.
  // After a one-cycle op start_i stays up, so the next call follows
  // back to back without a second assignment in the same time step.
  task go(input [4:0] op, input [7:0] rd, input [2:0] sel, input integer n);
    op_i = op;
    rd_val_i = rd;
    bit_sel_i = sel;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    lat = 1;
    while (done_o !== 1'b1 && lat < 8) begin
      start_i = 1'b0;
      @(negedge clk_sys_i);
      lat = lat + 1;
    end
    check("latency", lat, n);
  endtask
  task t_pmem;
    {r1_val_i, r0_val_i, z_ext_i, z_ptr_i} = 40'h1234_03_fffe;
    go(`OP_PMEM_STORE, 8'h00, 3'h0, 1);
    check("pmem_addr", pmem_addr_o, 24'h03fffe);
    check("pmem_data", pmem_wdata_o, 16'h1234);
    check("z_next", z_wdata_o, 24'h040000);
    check("pmem_z_we", {pmem_we_o, z_we_o}, 2'h3);
  endtask
  task t_io;
    io_addr_i = 6'h05;
    go(`OP_IO_OUT, 8'h3c, 3'h0, 1);
    go(`OP_IO_IN, 8'h00, 3'h0, 2);
    check("io_in", rd_wdata_o, 8'h3c);
    check("io_addr", io_addr_o, 6'h05);
  endtask
  task t_stack;
    sp_i = 16'h0020;
    go(`OP_PUSH, 8'h77, 3'h0, 1);
    check("sp_next", sp_wdata_o, 16'h001f);
    check("sp_we", sp_we_o, 1'h1);
    sp_i = 16'h001f;
    go(`OP_POP, 8'h00, 3'h0, 2);
    check("pop", rd_wdata_o, 8'h77);
    sram_i = 1'b1;
    go(`OP_POP, 8'h00, 3'h0, 3);
    check("pop_sram", rd_wdata_o, 8'h77);
    sram_i = 1'b0;
  endtask
  // Each atomic kind on its own byte, operand 5c.
  task t_atomic;
    reg [7:0] old, ex;
    for (k = 0; k < 4; k = k + 1) begin
      z_ptr_i = 16'h0040 + k[15:0];
      old = 8'he0 ^ k[7:0];
      case (k)
        0: ex = 8'h5c;
        1: ex = 8'h5c | old;
        2: ex = old & 8'ha3;
        default: ex = old ^ 8'h5c;
      endcase
      go(`OP_XCH + k[4:0], 8'h5c, 3'h0, 2);
      check("atomic_rd", rd_wdata_o, old);
      @(negedge clk_sys_i);
      check("atomic_mem", dmem.mem[8'h40 + k[7:0]], ex);
    end
  endtask
  task t_rot;
    go(`OP_FLAG_SET, 8'h00, 3'h0, 1);
    go(`OP_ROT_LEFT, 8'h89, 3'h0, 1);
    check("rol", rd_wdata_o, 8'h13);
    check("rol_hc", {status_register_o[5], status_register_o[0]}, 2'b11);
    go(`OP_ROT_RIGHT, 8'h02, 3'h0, 1);
    check("ror", rd_wdata_o, 8'h81);
    check("ror_hc", {status_register_o[5], status_register_o[0]}, 2'b10);
    go(`OP_FLAG_CLEAR, 8'h00, 3'h5, 1);
    check("h_clear", status_register_o[5], 1'b0);
  endtask
  task t_flags;
    for (k = 0; k < 8; k = k + 1) begin
      go(`OP_FLAG_CLEAR, 8'h00, k[2:0], 1);
    end
    for (k = 0; k < 8; k = k + 1) begin
      go(`OP_FLAG_SET, 8'h00, k[2:0], 1);
      check("flag_set", status_register_o, 8'hff >> (7 - k));
    end
    for (k = 0; k < 8; k = k + 1) begin
      go(`OP_FLAG_CLEAR, 8'h00, k[2:0], 1);
      check("flag_clr", status_register_o, (8'hfe << k) & 32'h0000_00ff);
    end
  endtask
  task t_bits;
    go(`OP_BIT_TO_T, 8'h10, 3'h4, 1);
    check("t_flag", status_register_o, 8'h40);
    go(`OP_T_TO_BIT, 8'h01, 3'h7, 1);
    check("bit_load", rd_wdata_o, 8'h81);
    check("bit_load_sr", status_register_o, 8'h40);
    io_addr_i = 6'h09;
    go(`OP_IO_BSET, 8'h00, 3'h2, 2);
    go(`OP_IO_BCLR, 8'h00, 3'h6, 2);
    @(negedge clk_sys_i);
    check("io_bits", iomem.mem[8'h09], 8'h1d);
  endtask
  task t_ctrl;
    for (k = 0; k < 4; k = k + 1) begin
      go(k == 3 ? `OP_NOP : `OP_WDOG_KICK + k[4:0], 8'hff, 3'h7, 1);
      check("ctrl_sr", status_register_o, 8'h40);
      check("ctrl_evt", {wdog_kick_o, sleep_o, break_o},
            k == 3 ? 3'h0 : 3'h4 >> k);
    end
  endtask
  // Main sequence after five clocks of reset.
  initial begin
    repeat (5) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    @(negedge clk_sys_i);
    t_pmem;
    t_io;
    t_stack;
    t_atomic;
    t_rot;
    t_flags;
    t_bits;
    t_ctrl;
    start_i = 1'b0;
    final_report;
  end
  // Watchdog well beyond the 67 clocks the run needs.
  initial begin
    #200000;
    fails = fails + 1;
    final_report;
  end
endmodule
